// *** rtl/dsc_device.sv ***
/*
 Drive end: holds the command word, runs the drive state machine, builds the state word.
 Assumes the master issues one request per pulse of cmd_valid and waits for rsp_valid.
*/
`timescale 1ns/1ns
module dsc_device
	import dsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	dsc_if.device link,
	input wire logic external_enable_input,
	input wire logic [7:0] op_mode,
	input wire logic fault_in,
	input wire logic motion_done,
	input wire logic velocity_reached,
	input wire logic speed_zero,
	input wire logic homing_attained,
	output logic motor_current_on,
	output logic move_start,
	output logic homing_start,
	output logic adopt_now,
	output logic blended_move,
	output logic halt_motion,
	output logic [7:0] drive_state
);
	// ==========================================================
	// State record
	typedef struct packed {
		dsc_state_t st;
		logic [15:0] cmd;
		logic start_seen;
		logic goal;
		logic setpoint_ack;
		logic pending;
		logic rsp_valid;
		logic rsp_err;
		logic [15:0] rsp_rdata;
		logic motor_on;
		logic move_start;
		logic homing_start;
		logic adopt;
		logic blend;
		logic halt;
	} dsc_dev_t;

	dsc_dev_t s_reg;
	dsc_dev_t s_next;

	// ==========================================================
	// State word assembly
	function automatic logic [15:0] dsc_status(input dsc_state_t st, input logic remote,
		input logic bit10, input logic bit12);
		logic [15:0] w;
		w = 16'h0000;
		case (st)
			DSC_NOT_READY: w = 16'h0000;
			DSC_SW_DISABLED: w[DSC_S_SOD] = 1'b1;
			DSC_READY: begin
				w[DSC_S_QSTOP] = 1'b1;
				w[DSC_S_RTSO] = 1'b1;
			end
			DSC_SWITCHED_ON: begin
				w[DSC_S_QSTOP] = 1'b1;
				w[DSC_S_SWON:DSC_S_RTSO] = 2'h3;
			end
			DSC_OP_ENABLED: begin
				w[DSC_S_QSTOP] = 1'b1;
				w[DSC_S_OPEN:DSC_S_RTSO] = 3'h7;
			end
			DSC_QSTOP_ACTIVE: w[DSC_S_OPEN:DSC_S_RTSO] = 3'h7;
			DSC_FAULT_REACT: w[DSC_S_FAULT:DSC_S_RTSO] = 4'hf;
			DSC_FAULT: w[DSC_S_FAULT] = 1'b1;
			default: w = 16'h0000;
		endcase
		w[DSC_S_REMOTE] = remote;
		w[DSC_S_GOAL] = bit10;
		w[DSC_S_MODE12] = bit12;
		return w;
	endfunction

	// ==========================================================
	// Next-state logic
	logic is_pp;
	logic is_pv;
	logic is_home;
	logic c_shutdown;
	logic c_swon;
	logic c_enable;
	logic c_novolt;
	logic c_qstop;
	logic start_rise;
	logic bit10;
	logic bit12;
	logic powered;

	always_comb begin
		s_next = s_reg;
		is_pp = (op_mode == DSC_MODE_PP);
		is_pv = (op_mode == DSC_MODE_PV);
		is_home = (op_mode == DSC_MODE_HOME);
		c_shutdown = ~s_reg.cmd[DSC_C_CLEAR] & s_reg.cmd[DSC_C_QSTOP] & s_reg.cmd[DSC_C_VOLT]
			& ~s_reg.cmd[DSC_C_SWON];
		c_swon = ~s_reg.cmd[DSC_C_CLEAR] & (s_reg.cmd[DSC_C_RUN:DSC_C_SWON] == 4'h7);
		c_enable = ~s_reg.cmd[DSC_C_CLEAR] & (s_reg.cmd[DSC_C_RUN:DSC_C_SWON] == 4'hf);
		c_novolt = ~s_reg.cmd[DSC_C_VOLT];
		c_qstop = s_reg.cmd[DSC_C_VOLT] & ~s_reg.cmd[DSC_C_QSTOP];
		powered = (s_reg.st == DSC_READY) | (s_reg.st == DSC_SWITCHED_ON)
			| (s_reg.st == DSC_OP_ENABLED) | (s_reg.st == DSC_QSTOP_ACTIVE);
		start_rise = s_reg.cmd[DSC_C_START] & ~s_reg.start_seen;
		// Link answer, one cycle after the request
		s_next.rsp_valid = 1'b0;
		s_next.rsp_err = 1'b0;
		s_next.rsp_rdata = 16'h0000;
		bit10 = is_pv ? velocity_reached : s_reg.goal;
		bit12 = is_pv ? speed_zero : (is_home ? homing_attained : s_reg.setpoint_ack);
		if (link.cmd_valid) begin
			s_next.rsp_valid = 1'b1;
			if (link.cmd_index == DSC_IDX_CMD) begin
				if (link.cmd_write) begin
					s_next.cmd = link.cmd_wdata;
				end
				s_next.rsp_rdata = s_reg.cmd;
			end else if (link.cmd_index == DSC_IDX_STAT && !link.cmd_write) begin
				s_next.rsp_rdata = dsc_status(s_reg.st, external_enable_input, bit10, bit12);
			end else begin
				s_next.rsp_err = 1'b1;
			end
		end
		// Drive state machine
		case (s_reg.st)
			DSC_NOT_READY: s_next.st = DSC_SW_DISABLED;
			DSC_SW_DISABLED: begin
				if (c_shutdown && external_enable_input) begin
					s_next.st = DSC_READY;
				end
			end
			DSC_READY: begin
				if (c_novolt || c_qstop) begin
					s_next.st = DSC_SW_DISABLED;
				end else if (c_enable) begin
					s_next.st = DSC_OP_ENABLED;
				end else if (c_swon) begin
					s_next.st = DSC_SWITCHED_ON;
				end
			end
			DSC_SWITCHED_ON: begin
				if (c_novolt || c_qstop) begin
					s_next.st = DSC_SW_DISABLED;
				end else if (c_shutdown) begin
					s_next.st = DSC_READY;
				end else if (c_enable) begin
					s_next.st = DSC_OP_ENABLED;
				end
			end
			DSC_OP_ENABLED: begin
				if (c_novolt) begin
					s_next.st = DSC_SW_DISABLED;
				end else if (c_qstop) begin
					s_next.st = DSC_QSTOP_ACTIVE;
				end else if (c_shutdown) begin
					s_next.st = DSC_READY;
				end else if (c_swon) begin
					s_next.st = DSC_SWITCHED_ON;
				end
			end
			DSC_QSTOP_ACTIVE: begin
				if (speed_zero || c_novolt) begin
					s_next.st = DSC_SW_DISABLED;
				end
			end
			DSC_FAULT_REACT: s_next.st = DSC_FAULT;
			DSC_FAULT: begin
				if (s_reg.cmd[DSC_C_CLEAR] && !fault_in) begin
					s_next.st = DSC_SW_DISABLED;
				end
			end
			default: s_next.st = DSC_NOT_READY;
		endcase
		if (powered && !external_enable_input) begin
			s_next.st = DSC_SW_DISABLED;
		end
		if (powered && fault_in) begin
			s_next.st = DSC_FAULT_REACT;
		end
		// Motion control
		s_next.start_seen = s_reg.cmd[DSC_C_START];
		s_next.move_start = 1'b0;
		s_next.homing_start = 1'b0;
		s_next.motor_on = (s_next.st == DSC_OP_ENABLED) | (s_next.st == DSC_QSTOP_ACTIVE);
		s_next.halt = (s_reg.st == DSC_OP_ENABLED) & s_reg.cmd[DSC_C_HALT];
		s_next.adopt = is_pp & s_reg.cmd[DSC_C_ADOPT];
		s_next.blend = is_pp & s_reg.cmd[DSC_C_BLEND];
		if (!s_reg.cmd[DSC_C_START]) begin
			s_next.setpoint_ack = 1'b0;
		end
		if (motion_done && !s_reg.move_start && !s_reg.homing_start) begin
			s_next.goal = 1'b1;
		end
		if (s_reg.st == DSC_OP_ENABLED && !s_reg.cmd[DSC_C_HALT]) begin
			if (is_home && start_rise) begin
				s_next.homing_start = 1'b1;
				s_next.goal = 1'b0;
			end
			if (is_pp && start_rise) begin
				s_next.setpoint_ack = 1'b1;
				if (s_reg.goal || s_reg.cmd[DSC_C_ADOPT]) begin
					s_next.move_start = 1'b1;
					s_next.goal = 1'b0;
				end else begin
					s_next.pending = 1'b1;
				end
			end else if (is_pp && s_reg.pending && (motion_done || s_reg.cmd[DSC_C_ADOPT])) begin
				s_next.pending = 1'b0;
				s_next.move_start = 1'b1;
				s_next.goal = 1'b0;
			end
		end else begin
			s_next.pending = 1'b0;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_reg <= '0;
			s_reg.st <= DSC_NOT_READY;
			s_reg.cmd <= DSC_CMD_RESET;
			s_reg.goal <= DSC_GOAL_RESET;
		end else begin
			s_reg <= s_next;
		end
	end

	assign link.rsp_valid = s_reg.rsp_valid;
	assign link.rsp_err = s_reg.rsp_err;
	assign link.rsp_rdata = s_reg.rsp_rdata;
	assign motor_current_on = s_reg.motor_on;
	assign move_start = s_reg.move_start;
	assign homing_start = s_reg.homing_start;
	assign adopt_now = s_reg.adopt;
	assign blended_move = s_reg.blend;
	assign halt_motion = s_reg.halt;
	assign drive_state = s_reg.st;
endmodule // dsc_device

// *** rtl/dsc_pkg.sv ***
/*
 Constants and types shared by both ends of the drive state control link.
 Assumes one 10 MHz clock, clk_sys, and a synchronous active-high reset.
*/
// Functional notes
// - Power-up auto-enters switch-on-disabled, status 0x0440
// - External enable high sets status bit 9
// - Shutdown command enters ready-to-switch-on state
// - Switch-on command enters switched-on state
// - Enable-operation command energises motor, operation enabled
// - State encoded in status bits 6,5,3..0
// - Position mode: bit10 goal, bit12 setpoint applied
// - Velocity mode: bit10 speed reached, bit12 stopped
// - Master keeps control bits 3..0 set
// - Control bit 4 starts homing or move
// - Control bit 5 adopts new parameters immediately
// - Control bit 9 selects blended or point moves
// - Master starts only after objects are written
package dsc_pkg;
	// ==========================================================
	// Object indices
	localparam logic [15:0] DSC_IDX_CMD = 16'h6040;
	localparam logic [15:0] DSC_IDX_STAT = 16'h6041;
	// ==========================================================
	// Operation modes
	localparam logic [7:0] DSC_MODE_PP = 8'h01;
	localparam logic [7:0] DSC_MODE_PV = 8'h03;
	localparam logic [7:0] DSC_MODE_HOME = 8'h06;
	// ==========================================================
	// Command word bit positions
	localparam int DSC_C_SWON = 0;
	localparam int DSC_C_VOLT = 1;
	localparam int DSC_C_QSTOP = 2;
	localparam int DSC_C_RUN = 3;
	localparam int DSC_C_START = 4;
	localparam int DSC_C_ADOPT = 5;
	localparam int DSC_C_CLEAR = 7;
	localparam int DSC_C_HALT = 8;
	localparam int DSC_C_BLEND = 9;
	// ==========================================================
	// State word bit positions
	localparam int DSC_S_RTSO = 0;
	localparam int DSC_S_SWON = 1;
	localparam int DSC_S_OPEN = 2;
	localparam int DSC_S_FAULT = 3;
	localparam int DSC_S_QSTOP = 5;
	localparam int DSC_S_SOD = 6;
	localparam int DSC_S_REMOTE = 9;
	localparam int DSC_S_GOAL = 10;
	localparam int DSC_S_MODE12 = 12;
	// ==========================================================
	// Reset values
	localparam logic [15:0] DSC_CMD_RESET = 16'h0000;
	localparam logic DSC_GOAL_RESET = 1'b1;
	// ==========================================================
	// Drive states, one-hot
	typedef enum logic [7:0] {
		DSC_NOT_READY = 8'h01,
		DSC_SW_DISABLED = 8'h02,
		DSC_READY = 8'h04,
		DSC_SWITCHED_ON = 8'h08,
		DSC_OP_ENABLED = 8'h10,
		DSC_QSTOP_ACTIVE = 8'h20,
		DSC_FAULT_REACT = 8'h40,
		DSC_FAULT = 8'h80
	} dsc_state_t;
endpackage

// *** rtl/dsc_if.sv ***
/*
 Word link between the bus master and the drive.
 Assumes both ends share clk_sys; one request is outstanding at a time.
*/
`timescale 1ns/1ns
interface dsc_if;
	logic cmd_valid;
	logic cmd_write;
	logic [15:0] cmd_index;
	logic [15:0] cmd_wdata;
	logic rsp_valid;
	logic rsp_err;
	logic [15:0] rsp_rdata;
	modport master (output cmd_valid, output cmd_write, output cmd_index, output cmd_wdata,
		input rsp_valid, input rsp_err, input rsp_rdata);
	modport device (input cmd_valid, input cmd_write, input cmd_index, input cmd_wdata,
		output rsp_valid, output rsp_err, output rsp_rdata);
endinterface

// *** rtl/dsc_master.sv ***
/*
 Master end: issues single word reads and writes toward the drive.
 Assumes the drive answers each request within a few cycles.
*/
`timescale 1ns/1ns
module dsc_master
	import dsc_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	dsc_if.master link,
	input wire logic req_valid,
	input wire logic req_write,
	input wire logic [15:0] req_index,
	input wire logic [15:0] req_wdata,
	input wire logic hold_enabled,
	input wire logic objects_ready,
	output logic req_ready,
	output logic resp_valid,
	output logic resp_err,
	output logic [15:0] resp_data,
	output logic op_enabled_seen
);
	// ==========================================================
	// State record
	typedef struct packed {
		logic busy;
		logic cmd_valid;
		logic cmd_write;
		logic [15:0] cmd_index;
		logic [15:0] cmd_wdata;
		logic resp_valid;
		logic resp_err;
		logic [15:0] resp_data;
		logic op_seen;
		logic last_read_stat;
	} dsc_mst_t;

	dsc_mst_t m_reg;
	dsc_mst_t m_next;
	logic [15:0] wdata;

	always_comb begin
		m_next = m_reg;
		m_next.cmd_valid = 1'b0;
		m_next.resp_valid = 1'b0;
		wdata = req_wdata;
		if (req_index == DSC_IDX_CMD) begin
			if (hold_enabled && m_reg.op_seen) begin
				wdata[DSC_C_RUN:DSC_C_SWON] = 4'hf;
			end
			if (!objects_ready) begin
				wdata[DSC_C_START] = 1'b0;
			end
		end
		if (!m_reg.busy && req_valid) begin
			m_next.busy = 1'b1;
			m_next.cmd_valid = 1'b1;
			m_next.cmd_write = req_write;
			m_next.cmd_index = req_index;
			m_next.cmd_wdata = wdata;
			m_next.last_read_stat = ~req_write & (req_index == DSC_IDX_STAT);
		end
		if (m_reg.busy && link.rsp_valid) begin
			m_next.busy = 1'b0;
			m_next.resp_valid = 1'b1;
			m_next.resp_err = link.rsp_err;
			m_next.resp_data = link.rsp_rdata;
			if (m_reg.last_read_stat && !link.rsp_err) begin
				m_next.op_seen = link.rsp_rdata[DSC_S_OPEN] & link.rsp_rdata[DSC_S_QSTOP];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			m_reg <= '0;
		end else begin
			m_reg <= m_next;
		end
	end

	assign link.cmd_valid = m_reg.cmd_valid;
	assign link.cmd_write = m_reg.cmd_write;
	assign link.cmd_index = m_reg.cmd_index;
	assign link.cmd_wdata = m_reg.cmd_wdata;
	assign req_ready = ~m_reg.busy;
	assign resp_valid = m_reg.resp_valid;
	assign resp_err = m_reg.resp_err;
	assign resp_data = m_reg.resp_data;
	assign op_enabled_seen = m_reg.op_seen;
endmodule // dsc_master

// *** tb/dsc_assertions.sv ***
/*
 Link checker for the drive state control pair.
 Assumes the bench wires it to the link interface and clk_sys.
*/
`timescale 1ns/1ns
module dsc_assertions (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [15:0] cmd_index,
	input wire logic [15:0] cmd_wdata,
	input wire logic rsp_valid,
	input wire logic rsp_err,
	input wire logic [15:0] rsp_rdata
);
	// ==========================================================
	// State word read tracking
	logic rd_reg;
	logic st;
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			rd_reg <= 1'b0;
		end else begin
			rd_reg <= cmd_valid && !cmd_write && cmd_index == 16'h6041;
		end
	end
	assign st = rsp_valid && rd_reg && !rsp_err;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// ==========================================================
	// Properties
	a_answer_next: assert property (cmd_valid |=> rsp_valid)
		else $error("answer missing");
	a_answer_cause: assert property (rsp_valid |-> $past(cmd_valid))
		else $error("answer without request");
	a_one_pending: assert property (cmd_valid |=> !cmd_valid [*2])
		else $error("requests too close");
	a_err_no_data: assert property (rsp_err |-> rsp_valid && rsp_rdata == 16'h0000)
		else $error("refusal carries data");
	a_ro_refused: assert property (cmd_valid && cmd_write && cmd_index == 16'h6041 |=> rsp_err)
		else $error("state word write accepted");
	a_cmd_accepted: assert property (cmd_valid && cmd_index == 16'h6040 |=> !rsp_err)
		else $error("command word refused");
	a_state_code: assert property (st |-> rsp_rdata[3:0] inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hf, 4'h8})
		else $error("illegal state code");
	a_sod_code: assert property (st && rsp_rdata[6] |-> rsp_rdata[5:0] == 6'h00)
		else $error("bad disabled code");
	a_ready_flags: assert property (st && rsp_rdata[3:0] == 4'h1 |-> rsp_rdata[6:5] == 2'b01)
		else $error("bad ready code");
	c_op_read: cover property (st && rsp_rdata == 16'h0627);
	c_refused: cover property (rsp_err);
	c_write: cover property (cmd_valid && cmd_write);
	c_qstop_read: cover property (st && !rsp_rdata[5] && rsp_rdata[2:0] == 3'h7);
	c_start_write: cover property (cmd_valid && cmd_write && cmd_wdata[4]);
endmodule // dsc_assertions

// *** tb/drive_state_control_tb.sv ***
/*
 Self-checking bench for master and drive joined by the link.
 Assumes a 10 MHz clk_sys and a synchronous active-high reset.
*/
`timescale 1ns/1ns
module drive_state_control_tb;
	import dsc_pkg::*;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic ext_en = 1'b0, fault_in = 1'b0, mdone = 1'b0, vreach = 1'b0, szero = 1'b0, hatt = 1'b0;
	logic [7:0] op_mode = DSC_MODE_PP;
	logic req_valid = 1'b0, req_write = 1'b0, hold_en = 1'b1, obj_rdy = 1'b1;
	logic [15:0] req_index = 16'h0000, req_wdata = 16'h0000;
	logic mcur, mstart, hstart, adopt, blend, halt, req_ready, resp_valid, resp_err, op_seen;
	logic [7:0] dstate;
	logic [15:0] resp_data;
	int n_mismatch = 0, n_checks = 0, n_mv = 0, n_hm = 0;
	localparam logic [49:0] ROWS [8] = '{
		{1'b1, 16'h6040, 16'h0006, 16'h0000, 1'b0}, {1'b0, 16'h6041, 16'h0000, 16'h0621, 1'b0},
		{1'b1, 16'h6040, 16'h0007, 16'h0006, 1'b0}, {1'b0, 16'h6041, 16'h0000, 16'h0623, 1'b0},
		{1'b1, 16'h6040, 16'h000f, 16'h0007, 1'b0}, {1'b0, 16'h6041, 16'h0000, 16'h0627, 1'b0},
		{1'b1, 16'h6041, 16'h1111, 16'h0000, 1'b1}, {1'b0, 16'h1234, 16'h0000, 16'h0000, 1'b1}};
	dsc_if lk();
	always #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		n_mv <= n_mv + int'(mstart);
		n_hm <= n_hm + int'(hstart);
	end
	dsc_device dsc_device_i (.clk_sys(clk_sys), .rst(rst), .link(lk.device), .external_enable_input(ext_en),
		.op_mode(op_mode), .fault_in(fault_in), .motion_done(mdone), .velocity_reached(vreach),
		.speed_zero(szero), .homing_attained(hatt), .motor_current_on(mcur), .move_start(mstart),
		.homing_start(hstart), .adopt_now(adopt), .blended_move(blend), .halt_motion(halt), .drive_state(dstate));
	dsc_master dsc_master_i (.clk_sys(clk_sys), .rst(rst), .link(lk.master), .req_valid(req_valid),
		.req_write(req_write), .req_index(req_index), .req_wdata(req_wdata), .hold_enabled(hold_en),
		.objects_ready(obj_rdy), .req_ready(req_ready), .resp_valid(resp_valid), .resp_err(resp_err),
		.resp_data(resp_data), .op_enabled_seen(op_seen));
	dsc_assertions dsc_assertions_i (.clk_sys(clk_sys), .rst(rst), .cmd_valid(lk.cmd_valid),
		.cmd_write(lk.cmd_write), .cmd_index(lk.cmd_index), .cmd_wdata(lk.cmd_wdata),
		.rsp_valid(lk.rsp_valid), .rsp_err(lk.rsp_err), .rsp_rdata(lk.rsp_rdata));
	// ==========================================================
	// Tasks
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task xfer(input logic w, input logic [15:0] i, input logic [15:0] d);
		int k;
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_write = w;
		req_index = i;
		req_wdata = d;
		@(negedge clk_sys);
		req_valid = 1'b0;
		chk("busy", 16'(req_ready), 16'h0000);
		k = 0;
		while (resp_valid !== 1'b1 && k < 20) begin
			@(negedge clk_sys);
			k++;
		end
		chk("answer", 16'(k < 20), 16'h0001);
		chk("ready", 16'(req_ready), 16'h0001);
	endtask
	task wr(input logic [15:0] d);
		xfer(1'b1, 16'h6040, d);
	endtask
	task rd(input logic [15:0] e);
		xfer(1'b0, 16'h6041, 16'h0000);
		chk("state", resp_data, e);
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_mismatch++;
		final_report;
	end
	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst = 1'b0;
		rd(16'h0440);
		chk("dstate", 16'(dstate), 16'h0002);
		ext_en = 1'b1;
		rd(16'h0640);
		for (int r = 0; r < 8; r++) begin
			xfer(ROWS[r][49], ROWS[r][48:33], ROWS[r][32:17]);
			chk("data", resp_data, ROWS[r][16:1]);
			chk("err", 16'(resp_err), 16'(ROWS[r][0]));
		end
		chk("motor", 16'(mcur), 16'h0001);
		chk("opseen", 16'(op_seen), 16'h0001);
		wr(16'h001f);
		rd(16'h1227);
		chk("starts", 16'(n_mv), 16'h0001);
		wr(16'h000f);
		rd(16'h0227);
		wr(16'h001f);
		rd(16'h1227);
		chk("starts", 16'(n_mv), 16'h0001);
		mdone = 1'b1;
		@(negedge clk_sys);
		mdone = 1'b0;
		wr(16'h000f);
		chk("starts", 16'(n_mv), 16'h0002);
		rd(16'h0227);
		mdone = 1'b1;
		@(negedge clk_sys);
		mdone = 1'b0;
		rd(16'h0627);
		wr(16'h022f);
		rd(16'h0627);
		chk("adopt", {15'h0, adopt}, 16'h0001);
		chk("blend", {15'h0, blend}, 16'h0001);
		wr(16'h011f);
		rd(16'h0627);
		chk("halt", {15'h0, halt}, 16'h0001);
		chk("starts", 16'(n_mv), 16'h0002);
		wr(16'h0000);
		rd(16'h0627);
		obj_rdy = 1'b0;
		wr(16'h001f);
		rd(16'h0627);
		chk("starts", 16'(n_mv), 16'h0002);
		obj_rdy = 1'b1;
		wr(16'h000f);
		op_mode = DSC_MODE_PV;
		vreach = 1'b1;
		szero = 1'b1;
		rd(16'h1627);
		vreach = 1'b0;
		szero = 1'b0;
		rd(16'h0227);
		op_mode = DSC_MODE_HOME;
		wr(16'h001f);
		wr(16'h000f);
		chk("homing", 16'(n_hm), 16'h0001);
		hatt = 1'b1;
		rd(16'h1227);
		hatt = 1'b0;
		fault_in = 1'b1;
		repeat (4) @(negedge clk_sys);
		rd(16'h0208);
		chk("fault", {11'h0, resp_data[6], resp_data[3:0]}, 16'h0008);
		chk("dstate", 16'(dstate), 16'h0080);
		chk("motor", 16'(mcur), 16'h0000);
		chk("opseen", 16'(op_seen), 16'h0000);
		fault_in = 1'b0;
		wr(16'h0080);
		rd(16'h0240);
		chk("clear", {9'h0, resp_data[6:0]}, 16'h0040);
		chk("dstate", 16'(dstate), 16'h0002);
		// Quick stop from operation enabled, left on zero speed
		hold_en = 1'b0;
		wr(16'h0006);
		wr(16'h000f);
		wr(16'h000b);
		rd(16'h0207);
		chk("motor", 16'(mcur), 16'h0001);
		szero = 1'b1;
		@(negedge clk_sys);
		szero = 1'b0;
		rd(16'h0240);
		chk("motor", 16'(mcur), 16'h0000);
		// Reset in mid-run
		rst = 1'b1;
		repeat (2) @(negedge clk_sys);
		rst = 1'b0;
		rd(16'h0640);
		chk("dstate", 16'(dstate), 16'h0002);
		final_report;
	end
endmodule // drive_state_control_tb
